//--- hdl/card_status_change_flags.v
// Two-socket card status-change flag registers with indexed read and write access.
`timescale 1ns/1ps
`default_nettype none
`include "card_status_change_regs.vh"

module card_status_change_flags (
    // Clock and resets
    input  wire       sys_clk,
    input  wire       reset_n,
    input  wire       bus_reset_n,
    input  wire       wakeup_power_event,
    // Indexed register access
    input  wire [7:0] reg_index,
    input  wire       reg_read,
    input  wire       reg_write,
    input  wire [7:0] reg_write_data,
    output reg  [7:0] reg_read_data,
    output reg        reg_read_valid,
    // Global control
    input  wire       clear_mode_select,
    // Socket A pins and configuration
    input  wire       a_card_detect_1_n,
    input  wire       a_card_detect_2_n,
    input  wire       a_card_ready,
    input  wire       a_battery_voltage_2,
    input  wire       a_battery_voltage_1_ri,
    input  wire [3:0] a_card_detect_irq_enable,
    input  wire       a_card_kind_select,
    input  wire       a_ring_indicate_enable,
    // Socket B pins and configuration
    input  wire       b_card_detect_1_n,
    input  wire       b_card_detect_2_n,
    input  wire       b_card_ready,
    input  wire       b_battery_voltage_2,
    input  wire       b_battery_voltage_1_ri,
    input  wire [3:0] b_card_detect_irq_enable,
    input  wire       b_card_kind_select,
    input  wire       b_ring_indicate_enable
);

    // ************************************************************
    // Visible-bit mask
    // ************************************************************

    // Positions the host may see: enabled sources, and for an I/O card
    // never the ready or battery-warning positions.
    function [3:0] visible_mask;
        input [3:0] enable;
        input       card_kind;
        begin
            visible_mask = enable;
            if (card_kind == `CARD_KIND_IO) begin
                visible_mask[`READY_RISE_BIT]      = 1'b0;
                visible_mask[`BATTERY_WARNING_BIT] = 1'b0;
            end
        end
    endfunction

    // Index decode shared by both sockets' read and clear paths.
    function index_hit;
        input [7:0] index;
        input [7:0] target;
        begin
            index_hit = (index == target);
        end
    endfunction

    // ************************************************************
    // Bus reset synchroniser
    // ************************************************************
    reg        bus_reset_s1_q;
    reg        bus_reset_s2_q;
    reg        wakeup_s1_q;
    reg        wakeup_s2_q;
    wire       flags_clear;

    // Bus reset and the wakeup enable come from another domain; two stages each.
    // A bus reset shorter than one clock cycle may be missed; it is a level.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_reset_s1_q <= 1'b1;
            bus_reset_s2_q <= 1'b1;
            wakeup_s1_q    <= 1'b0;
            wakeup_s2_q    <= 1'b0;
        end else begin
            bus_reset_s1_q <= bus_reset_n;
            bus_reset_s2_q <= bus_reset_s1_q;
            wakeup_s1_q    <= wakeup_power_event;
            wakeup_s2_q    <= wakeup_s1_q;
        end
    end

    // With wakeup enabled the flags must survive a bus reset, so only the
    // global reset reaches them then.
    assign flags_clear = ~bus_reset_s2_q & ~wakeup_s2_q;

    // ************************************************************
    // Address decode and clear requests
    // ************************************************************
    // Flag state from each socket, and the host's view of it after masking.
    wire [3:0] flags_a;
    wire [3:0] flags_b;
    wire [3:0] view_a;
    wire [3:0] view_b;
    wire       hit_a;
    wire       hit_b;
    reg  [3:0] clear_a;
    reg  [3:0] clear_b;
    reg  [7:0] read_d;

    assign hit_a  = index_hit(reg_index, `SOCKET_A_STATUS_CHANGE_FLAGS_INDEX);
    assign hit_b  = index_hit(reg_index, `SOCKET_B_STATUS_CHANGE_FLAGS_INDEX);
    assign view_a = flags_a & visible_mask(a_card_detect_irq_enable, a_card_kind_select);
    assign view_b = flags_b & visible_mask(b_card_detect_irq_enable, b_card_kind_select);

    // Clear requests: in read mode a read clears exactly what it returned, so
    // a flag set after the read is never lost; in write mode a one clears.
    // Upper data bits are dropped here, which makes writes to them no-ops.
    // Software is expected to read first and clear after; an event that lands
    // in the clearing cycle is kept so that no source is lost.
    always @* begin
        clear_a = `FLAGS_NONE;
        clear_b = `FLAGS_NONE;
        if (clear_mode_select == `CLEAR_MODE_ON_READ) begin
            if (reg_read && hit_a) begin
                clear_a = view_a;
            end
            if (reg_read && hit_b) begin
                clear_b = view_b;
            end
        end else begin
            if (reg_write && hit_a) begin
                clear_a = reg_write_data[3:0];
            end
            if (reg_write && hit_b) begin
                clear_b = reg_write_data[3:0];
            end
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************

    // Unmapped indices read as zero; the upper nibble is always zero.
    // Masking at read time as well as at capture means a source disabled
    // after its flag was set stops showing at once.
    always @* begin
        read_d = `STATUS_CHANGE_FLAGS_RESET;
        if (hit_a) begin
            read_d = {4'h0, view_a};
        end else if (hit_b) begin
            read_d = {4'h0, view_b};
        end
    end

    // Read answer is registered: data and valid appear one edge after the request.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_read_data  <= `STATUS_CHANGE_FLAGS_RESET;
            reg_read_valid <= 1'b0;
        end else begin
            reg_read_valid <= reg_read;
            if (reg_read) begin
                reg_read_data <= read_d;
            end
        end
    end

    // ************************************************************
    // Socket flag latches
    // ************************************************************
    socket_change_latch socket_a (
        .sys_clk                (sys_clk),
        .reset_n                (reset_n),
        .flags_clear            (flags_clear),
        .card_detect_1_n        (a_card_detect_1_n),
        .card_detect_2_n        (a_card_detect_2_n),
        .card_ready             (a_card_ready),
        .battery_voltage_2      (a_battery_voltage_2),
        .battery_voltage_1_ri   (a_battery_voltage_1_ri),
        .card_detect_irq_enable (a_card_detect_irq_enable),
        .card_kind_select       (a_card_kind_select),
        .ring_indicate_enable   (a_ring_indicate_enable),
        .clear_bits             (clear_a),
        .flags                  (flags_a)
    );

    socket_change_latch socket_b (
        .sys_clk                (sys_clk),
        .reset_n                (reset_n),
        .flags_clear            (flags_clear),
        .card_detect_1_n        (b_card_detect_1_n),
        .card_detect_2_n        (b_card_detect_2_n),
        .card_ready             (b_card_ready),
        .battery_voltage_2      (b_battery_voltage_2),
        .battery_voltage_1_ri   (b_battery_voltage_1_ri),
        .card_detect_irq_enable (b_card_detect_irq_enable),
        .card_kind_select       (b_card_kind_select),
        .ring_indicate_enable   (b_ring_indicate_enable),
        .clear_bits             (clear_b),
        .flags                  (flags_b)
    );

endmodule
`default_nettype wire

//--- hdl/card_status_change_regs.vh
// Register indices, field positions and reset values for the status-change flags.
`ifndef CARD_STATUS_CHANGE_REGS_VH
`define CARD_STATUS_CHANGE_REGS_VH

// ************************************************************
// Register indices, memory offset and reset value
// ************************************************************
`define SOCKET_A_STATUS_CHANGE_FLAGS_INDEX 8'h04
`define SOCKET_B_STATUS_CHANGE_FLAGS_INDEX 8'h44
`define STATUS_CHANGE_FLAGS_MEM_OFFSET     12'h804
`define STATUS_CHANGE_FLAGS_RESET          8'h00

// ************************************************************
// Field positions
// ************************************************************
`define CARD_DETECT_CHANGE_BIT 3
`define READY_RISE_BIT         2
`define BATTERY_WARNING_BIT    1
`define BATTERY_DEAD_BIT       0
`define FLAG_COUNT             4
`define CLEAR_MODE_BIT         2

// ************************************************************
// Field values
// ************************************************************
`define CARD_KIND_MEMORY       1'b0
`define CARD_KIND_IO           1'b1
`define CLEAR_MODE_ON_READ     1'b0
`define CLEAR_MODE_WRITE_ONE   1'b1
`define FLAGS_NONE             4'h0

`endif

//--- hdl/socket_change_latch.v
// Per-socket pin synchronisers, event detection and sticky flag storage.
`timescale 1ns/1ps
`default_nettype none
`include "card_status_change_regs.vh"

module socket_change_latch (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       reset_n,
    input  wire       flags_clear,
    // Card pins, all asynchronous to sys_clk
    input  wire       card_detect_1_n,
    input  wire       card_detect_2_n,
    input  wire       card_ready,
    input  wire       battery_voltage_2,
    input  wire       battery_voltage_1_ri,
    // Configuration
    input  wire [3:0] card_detect_irq_enable,
    input  wire       card_kind_select,
    input  wire       ring_indicate_enable,
    // Clear request and flag state
    input  wire [3:0] clear_bits,
    output wire [3:0] flags
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    reg  [4:0] sync1_q;
    reg  [4:0] sync2_q;
    reg  [4:0] last_q;
    reg  [3:0] flags_q;
    reg  [3:0] event_d;
    reg  [3:0] flags_d;
    wire [4:0] pins;

    assign pins  = {card_detect_1_n, card_detect_2_n, card_ready,
                    battery_voltage_2, battery_voltage_1_ri};
    assign flags = flags_q;

    // Two stages before any logic looks at the pins; last_q feeds the edge detectors.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 5'h1F;
            sync2_q <= 5'h1F;
            last_q  <= 5'h1F;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            last_q  <= sync2_q;
        end
    end

    // Event detection; disabled sources never raise their flag.
    always @* begin
        event_d = `FLAGS_NONE;
        // Either detect line changing level counts.
        event_d[`CARD_DETECT_CHANGE_BIT] = (sync2_q[4] != last_q[4])
                                         | (sync2_q[3] != last_q[3]);
        if (card_kind_select == `CARD_KIND_MEMORY) begin
            event_d[`READY_RISE_BIT]      = sync2_q[2] & ~last_q[2];
            event_d[`BATTERY_WARNING_BIT] = ~sync2_q[1] & last_q[1];
            event_d[`BATTERY_DEAD_BIT]    = ~sync2_q[0] & last_q[0];
        end else begin
            // The status-change line of an I/O card is active low.
            event_d[`BATTERY_DEAD_BIT]    = ~sync2_q[0] & last_q[0];
        end
        // In ring mode the shared battery pin is the ring line, active low,
        // and bit 0 reports it whatever the card kind.
        if (ring_indicate_enable) begin
            event_d[`BATTERY_DEAD_BIT]    = ~sync2_q[0] & last_q[0];
        end
        event_d = event_d & card_detect_irq_enable;
    end

    // Sticky flags: an event in the clearing cycle survives the clear.
    always @* begin
        flags_d = (flags_q & ~clear_bits) | event_d;
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_q <= `FLAGS_NONE;
        end else if (flags_clear) begin
            flags_q <= `FLAGS_NONE;
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule
`default_nettype wire

//--- testbench/card_pin_model.sv
// Behavioural card model that drives one socket's status lines.
`timescale 1ns/1ps
`default_nettype none
module card_pin_model (
    // Levels: detect 1, detect 2, ready, warning, dead or ring
    input  wire logic [4:0] levels,
    // Socket lines in the same order
    output var  logic [4:0] pins
);
    // A seated card always drives its lines, so they never float.
    always_comb begin
        pins = levels;
    end
endmodule
`default_nettype wire

//--- testbench/card_status_change_assertions.sv
// Concurrent checks on the status-change register port.
`timescale 1ns/1ps
`default_nettype none
module card_status_change_checker (
    // Clock and resets
    input wire logic       sys_clk,
    input wire logic       reset_n,
    input wire logic       bus_reset_n,
    input wire logic       wakeup_power_event,
    // Register port
    input wire logic [7:0] reg_index,
    input wire logic       reg_read,
    input wire logic       reg_write,
    input wire logic       clear_mode_select,
    input wire logic [7:0] reg_read_data,
    input wire logic       reg_read_valid,
    // Source configuration
    input wire logic [3:0] a_card_detect_irq_enable,
    input wire logic [3:0] b_card_detect_irq_enable,
    input wire logic       a_card_kind_select
);
    logic sel_a;
    logic sel_b;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Decode the two mapped indices once.
    assign sel_a = reg_index == 8'h04;
    assign sel_b = reg_index == 8'h44;
    // Each read is answered one cycle later, and only then.
    read_answer_a: assert property (reg_read |=> reg_read_valid)
        else $error("read not answered");
    valid_cause_a: assert property (reg_read_valid |-> $past(reg_read))
        else $error("answer without a read");
    upper_zero_a: assert property (reg_read_valid |-> reg_read_data[7:4] == 4'h0)
        else $error("upper bits not zero");
    unmapped_zero_a: assert property (reg_read && !sel_a && !sel_b |=> reg_read_data == 8'h00)
        else $error("unmapped index returned data");
    // Masking is checked at read time, so stale flags cannot leak out.
    disabled_zero_a: assert property (reg_read && (sel_a && a_card_detect_irq_enable == 4'h0
        || sel_b && b_card_detect_irq_enable == 4'h0) |=> reg_read_data == 8'h00)
        else $error("disabled sources read nonzero");
    io_mask_a: assert property (reg_read && sel_a && a_card_kind_select |=> reg_read_data[2:1] == 2'b00)
        else $error("I/O card shows ready or warning");
    data_hold_a: assert property (!reg_read |=> $stable(reg_read_data))
        else $error("read data moved without a read");
    // Six cycles covers the two sync stages plus the clearing edge.
    bus_clear_a: assert property ((!bus_reset_n && !wakeup_power_event)[*6] ##0 reg_read
        |=> reg_read_data == 8'h00)
        else $error("bus reset left flags set");
    cover property (reg_read_valid && reg_read_data[3:0] == 4'hF);
    cover property (reg_write && clear_mode_select && sel_a);
    cover property (!bus_reset_n && !wakeup_power_event && reg_read);
endmodule
bind card_status_change_flags card_status_change_checker card_status_change_checker_inst (
    .sys_clk, .reset_n, .bus_reset_n, .wakeup_power_event, .reg_index, .reg_read, .reg_write,
    .clear_mode_select, .reg_read_data, .reg_read_valid, .a_card_detect_irq_enable,
    .b_card_detect_irq_enable, .a_card_kind_select
);
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the two-socket status-change flags.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ******************************
    // Stimulus and observation
    // ******************************
    logic       sys_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       bus_reset_n = 1'b1;
    logic       wakeup_power_event = 1'b0;
    logic [7:0] reg_index = 8'h00;
    logic       reg_read = 1'b0;
    logic       reg_write = 1'b0;
    logic [7:0] reg_write_data = 8'h00;
    logic       clear_mode_select = 1'b0;
    logic [4:0] a_lv = 5'h03;
    logic [4:0] b_lv = 5'h03;
    logic [3:0] a_en = 4'h0;
    logic [3:0] b_en = 4'h0;
    logic       a_kind = 1'b0;
    logic       a_ring = 1'b0;
    logic       b_kind = 1'b0;
    wire  logic [7:0] reg_read_data;
    wire  logic       reg_read_valid;
    wire  logic [4:0] a_pin;
    wire  logic [4:0] b_pin;
    int         mismatches = 0;
    int         tests_run = 0;
    int         cycles = 0;
    card_pin_model card_pin_model_inst (.levels(a_lv), .pins(a_pin));
    card_pin_model card_pin_model_b_inst (.levels(b_lv), .pins(b_pin));
    card_status_change_flags card_status_change_flags_inst (
        .sys_clk, .reset_n, .bus_reset_n, .wakeup_power_event, .reg_index, .reg_read,
        .reg_write, .reg_write_data, .reg_read_data, .reg_read_valid, .clear_mode_select,
        .a_card_detect_1_n(a_pin[4]), .a_card_detect_2_n(a_pin[3]), .a_card_ready(a_pin[2]),
        .a_battery_voltage_2(a_pin[1]), .a_battery_voltage_1_ri(a_pin[0]),
        .a_card_detect_irq_enable(a_en), .a_card_kind_select(a_kind),
        .a_ring_indicate_enable(a_ring),
        .b_card_detect_1_n(b_pin[4]), .b_card_detect_2_n(b_pin[3]), .b_card_ready(b_pin[2]),
        .b_battery_voltage_2(b_pin[1]), .b_battery_voltage_1_ri(b_pin[0]),
        .b_card_detect_irq_enable(b_en), .b_card_kind_select(b_kind),
        .b_ring_indicate_enable(a_ring)
    );
    // Clock and a hang guard well above the expected run length.
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Callers sit at a falling edge; data is settled two falling edges on.
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        reg_read = 1'b1;
        reg_index = idx;
        @(negedge sys_clk);
        reg_read = 1'b0;
        chk({7'h00, reg_read_valid}, 8'h01);
        @(negedge sys_clk);
        chk({7'h00, reg_read_valid}, 8'h00);
        chk(reg_read_data, exp);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        reg_write = 1'b1;
        reg_index = idx;
        reg_write_data = data;
        @(negedge sys_clk);
        reg_write = 1'b0;
    endtask
    // Five cycles lets a pin change cross the sync stages into a flag.
    task automatic pins(input logic [4:0] a, input logic [4:0] b);
        a_lv = a;
        b_lv = b;
        repeat (5) @(negedge sys_clk);
    endtask
    task automatic bus_reset(input logic wake, input logic [7:0] exp);
        wakeup_power_event = wake;
        repeat (3) @(negedge sys_clk);
        bus_reset_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        rd(8'h04, exp);
        bus_reset_n = 1'b1;
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Pins start away from the synchroniser reset value, but all sources are disabled then, so no stray flags.
    initial begin
        repeat (16) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        rd(8'h04, 8'h00);
        rd(8'h44, 8'h00);
        $display("Test defaults done");
        a_en = 4'hF;
        pins(5'h14, 5'h14);
        rd(8'h04, 8'h0F);
        rd(8'h04, 8'h00);
        rd(8'h44, 8'h00);
        b_en = 4'h8;
        pins(5'h14, 5'h04);
        wr(8'h44, 8'h0F);
        rd(8'h44, 8'h08);
        $display("Test clear on read done");
        a_kind = 1'b1;
        b_kind = 1'b1;
        b_en = 4'hF;
        pins(5'h13, 5'h13);
        pins(5'h14, 5'h14);
        rd(8'h04, 8'h01);
        rd(8'h44, 8'h09);
        a_kind = 1'b0;
        b_kind = 1'b0;
        a_ring = 1'b1;
        a_en = 4'h1;
        pins(5'h13, 5'h04);
        pins(5'h14, 5'h04);
        rd(8'h04, 8'h01);
        $display("Test card kinds done");
        clear_mode_select = 1'b1;
        a_ring = 1'b0;
        a_en = 4'hF;
        pins(5'h04, 5'h04);
        rd(8'h04, 8'h08);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        wr(8'h04, 8'hF7);
        rd(8'h04, 8'h08);
        wr(8'h04, 8'h08);
        rd(8'h04, 8'h00);
        $display("Test write one clear done");
        pins(5'h13, 5'h04);
        pins(5'h14, 5'h04);
        bus_reset(1'b1, 8'h0F);
        bus_reset(1'b0, 8'h00);
        $display("Test bus reset done");
        end_sim();
    end
endmodule
`default_nettype wire
